// file: spbc_pkg.sv
package spbc_pkg;
	// ----------------------------------------
	// clock and link timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCK_HALF_NS = 200;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);
	localparam int CS_HIGH_NS = 250;
	localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] CS_HIGH_LAST = 3'(CS_HIGH_CYC - 1);

	// ----------------------------------------
	// device opcodes and framing
	// ----------------------------------------
	localparam logic [7:0] CMD_SEC_PROG = 8'h9b;
	localparam logic [7:0] CMD_SEC_READ = 8'h77;
	localparam logic [7:0] CMD_XFER_B1 = 8'h53;
	localparam logic [7:0] CMD_XFER_B2 = 8'h55;
	localparam logic [7:0] CMD_COMP_B1 = 8'h60;
	localparam logic [7:0] CMD_COMP_B2 = 8'h61;
	localparam logic [7:0] CMD_REWR_B1 = 8'h58;
	localparam logic [7:0] CMD_REWR_B2 = 8'h59;
	localparam logic [7:0] CMD_STATUS = 8'hd7;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [7:0] HDR_LAST = 8'h03;
	localparam logic [7:0] SEC_RD_LAST = 8'h7f;
	localparam logic [6:0] SEC_USER_LAST = 7'h3f;
	localparam int ST_READY_BIT = 7;
	localparam int ST_COMP_BIT = 6;
	localparam int ST_PSIZE_BIT = 0;
	localparam int PAGE_W = 13;
	localparam int SECTOR_LSB = 8;

	// ----------------------------------------
	// controller registers
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PAGE = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_WBUF = 8'h0c;
	localparam logic [7:0] REG_RBUF = 8'h10;
	localparam logic [7:0] REG_WEAR = 8'h14;
	localparam int CTRL_BUF_BIT = 3;
	localparam int CTRL_LEN_LSB = 8;
	localparam int WBUF_IDX_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_LOCKED_BIT = 3;
	localparam int STAT_WEAR_BIT = 4;
	localparam int STAT_DEV_LSB = 8;
	localparam logic [13:0] WEAR_LIMIT = 14'd10000;

	typedef enum logic [2:0] {
		OP_STATUS = 3'h0,
		OP_SEC_PROG = 3'h1,
		OP_SEC_READ = 3'h2,
		OP_XFER = 3'h3,
		OP_COMP = 3'h4,
		OP_REWR = 3'h5
	} spbc_op_e;
	localparam logic [2:0] OP_LAST = 3'h5;
endpackage

// file: spbc_byte_if.sv
`timescale 1ns/1ps
interface spbc_byte_if;
	logic start;
	logic [7:0] tx;
	logic so_s;
	logic done;
	logic [7:0] rx;
	logic busy;
	logic sck;
	logic si;
	modport seq (output start, output tx, output so_s,
		input done, input rx, input busy, input sck, input si);
	modport eng (input start, input tx, input so_s,
		output done, output rx, output busy, output sck, output si);
endinterface

// file: spbc_shifter.sv
`timescale 1ns/1ps
module spbc_shifter (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// byte channel to the sequencer
	spbc_byte_if.eng bi
);
	import spbc_pkg::*;

	typedef enum logic [2:0] {
		SH_IDLE = 3'b001,
		SH_LOW = 3'b010,
		SH_HIGH = 3'b100
	} spbc_sh_e;

	spbc_sh_e st_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic [2:0] bit_q;
	logic sck_q;
	logic si_q;
	logic done_q;
	logic half_end;

	// ----------------------------------------
	// half period divider
	// ----------------------------------------
	assign half_end = (cnt_q == SCK_HALF_LAST);

	// counts only while a byte is on the wire
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
		end else if (st_q == SH_IDLE || half_end) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// ----------------------------------------
	// mode 0 bit engine, msb first
	// ----------------------------------------
	// so is sampled just before sck falls: the two-flop delay then lands
	// the sample two cycles after the rising edge, mid high phase, where the device data is stable
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= SH_IDLE;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			bit_q <= 3'h0;
			sck_q <= 1'b0;
			si_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				SH_IDLE: if (bi.start) begin
					sh_q <= bi.tx;
					si_q <= bi.tx[7];
					bit_q <= 3'h7;
					st_q <= SH_LOW;
				end
				SH_LOW: if (half_end) begin
					sck_q <= 1'b1;
					st_q <= SH_HIGH;
				end
				SH_HIGH: if (half_end) begin
					sck_q <= 1'b0;
					sh_q <= {sh_q[6:0], bi.so_s};
					si_q <= sh_q[6];
					if (bit_q == 3'h0) begin
						rx_q <= {sh_q[6:0], bi.so_s};
						done_q <= 1'b1;
						st_q <= SH_IDLE;
					end else begin
						bit_q <= bit_q - 3'h1;
						st_q <= SH_LOW;
					end
				end
				default: st_q <= SH_IDLE;
			endcase
		end
	end

	assign bi.busy = (st_q != SH_IDLE);
	assign bi.done = done_q;
	assign bi.rx = rx_q;
	assign bi.sck = sck_q;
	assign bi.si = si_q;
endmodule

// file: spbc_host.sv
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - program sends 9B 00 00 00 then data
// - raise select after data, poll busy
// - read sends 77 plus three dummy bytes
// - transfer uses 53 or 55 plus address
// - 1056 pages: 13 page bits, 11 ignored
// - 1024 pages: address bits 22..10, 10 ignored
// - select low for header; rise starts transfer
// - compare uses 60 or 61 plus address
// - rewrite uses 58 or 59 plus address
// - rewrite sector pages within 10000 operations (not done here: rewrites per sector are only counted, flagged at the 10000th)
module spbc_host (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// flash pins
	output logic CS_N,
	output logic SCK,
	output logic SI,
	input wire logic SO
);
	import spbc_pkg::*;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_HDR = 7'b0000010,
		ST_WR = 7'b0000100,
		ST_RD = 7'b0001000,
		ST_GAP = 7'b0010000,
		ST_POLL = 7'b0100000,
		ST_STAT = 7'b1000000
	} spbc_st_e;

	spbc_byte_if bi ();

	spbc_st_e st_q;
	spbc_op_e op_q;
	logic buf2_q;
	logic [PAGE_W-1:0] page_q;
	logic [6:0] len_q;
	logic [7:0] cnt_q;
	logic [2:0] gap_q;
	logic pend_q;
	logic poll_next_q;
	logic cs_n_q;
	logic psize_q;
	logic [7:0] dstat_q;
	logic done_q;
	logic refused_q;
	logic locked_q;
	logic wear_q;
	logic [6:0] ridx_q;
	logic [4:0] wsel_q;
	logic so_m_q;
	logic so_s_q;
	logic [31:0] rdata_q;
	logic [7:0] pbuf [64];
	logic [7:0] rbuf [128];
	logic [13:0] wear_cnt [32];

	logic go;
	logic start_req;
	logic op_legal;
	logic finish;
	logic [7:0] opcode;
	logic [23:0] addr24;
	logic [7:0] hdr_byte;
	logic [7:0] tx_byte;
	logic [6:0] len_last;
	logic [4:0] sector;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			so_m_q <= 1'b0;
			so_s_q <= 1'b0;
		end else begin
			so_m_q <= SO;
			so_s_q <= so_m_q;
		end
	end

	spbc_shifter u_shifter (
		.core_clk(CORE_CLK),
		.rst_n(RST_N),
		.bi(bi.eng)
	);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	assign op_legal = (WDATA[2:0] <= OP_LAST);
	// an illegal code or a second user-area program is refused, never sent
	assign start_req = WR && ADDR == REG_CTRL;
	assign go = start_req && op_legal && st_q == ST_IDLE
		&& !(spbc_op_e'(WDATA[2:0]) == OP_SEC_PROG && locked_q);
	assign finish = st_q == ST_GAP && gap_q == CS_HIGH_LAST && !poll_next_q;
	assign sector = page_q[PAGE_W-1:SECTOR_LSB];
	assign len_last = (len_q == 7'h00) ? SEC_USER_LAST : len_q - 7'h01;

	// opcode per operation and buffer
	always_comb begin
		opcode = CMD_STATUS;
		if (op_q == OP_SEC_PROG) opcode = CMD_SEC_PROG;
		if (op_q == OP_SEC_READ) opcode = CMD_SEC_READ;
		if (op_q == OP_XFER) opcode = buf2_q ? CMD_XFER_B2 : CMD_XFER_B1;
		if (op_q == OP_COMP) opcode = buf2_q ? CMD_COMP_B2 : CMD_COMP_B1;
		if (op_q == OP_REWR) opcode = buf2_q ? CMD_REWR_B2 : CMD_REWR_B1;
	end

	// page layout follows the page size last seen in device status
	always_comb begin
		if (psize_q) begin
			addr24 = {1'b0, page_q, 10'h000};
		end else begin
			addr24 = {page_q, 11'h000};
		end
	end

	// header: opcode then three address, filler or dummy bytes
	always_comb begin
		hdr_byte = opcode;
		if (op_q == OP_SEC_PROG || op_q == OP_SEC_READ) begin
			if (cnt_q[1:0] != 2'h0) hdr_byte = FILL_BYTE;
		end else begin
			if (cnt_q[1:0] == 2'h1) hdr_byte = addr24[23:16];
			if (cnt_q[1:0] == 2'h2) hdr_byte = addr24[15:8];
			if (cnt_q[1:0] == 2'h3) hdr_byte = addr24[7:0];
		end
	end

	// byte to shift next; user data only, the factory half is never sent
	always_comb begin
		tx_byte = FILL_BYTE;
		if (st_q == ST_HDR) tx_byte = hdr_byte;
		if (st_q == ST_WR) tx_byte = pbuf[cnt_q[5:0]];
		if (st_q == ST_POLL) tx_byte = CMD_STATUS;
	end

	assign bi.start = pend_q;
	assign bi.tx = tx_byte;
	assign bi.so_s = so_s_q;

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= ST_IDLE;
			cnt_q <= 8'h00;
			pend_q <= 1'b0;
			poll_next_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			pend_q <= 1'b0;
			unique case (st_q)
				ST_IDLE: if (go) begin
					cs_n_q <= 1'b0;
					pend_q <= 1'b1;
					cnt_q <= 8'h00;
					st_q <= (spbc_op_e'(WDATA[2:0]) == OP_STATUS) ? ST_POLL : ST_HDR;
				end
				ST_HDR: if (bi.done) begin
					cnt_q <= (cnt_q == HDR_LAST) ? 8'h00 : cnt_q + 8'h01;
					if (cnt_q != HDR_LAST) begin
						pend_q <= 1'b1;
					end else if (op_q == OP_SEC_PROG) begin
						pend_q <= 1'b1;
						st_q <= ST_WR;
					end else if (op_q == OP_SEC_READ) begin
						pend_q <= 1'b1;
						st_q <= ST_RD;
					end else begin
						cs_n_q <= 1'b1;
						poll_next_q <= 1'b1;
						st_q <= ST_GAP;
					end
				end
				// count may exceed 64; the pointer wraps like the device's
				ST_WR: if (bi.done) begin
					if (cnt_q[6:0] == len_last) begin
						cs_n_q <= 1'b1;
						poll_next_q <= 1'b1;
						st_q <= ST_GAP;
					end else begin
						cnt_q <= cnt_q + 8'h01;
						pend_q <= 1'b1;
					end
				end
				ST_RD: if (bi.done) begin
					if (cnt_q == SEC_RD_LAST) begin
						cs_n_q <= 1'b1;
						poll_next_q <= 1'b0;
						st_q <= ST_GAP;
					end else begin
						cnt_q <= cnt_q + 8'h01;
						pend_q <= 1'b1;
					end
				end
				ST_GAP: if (gap_q == CS_HIGH_LAST) begin
					if (poll_next_q) begin
						cs_n_q <= 1'b0;
						pend_q <= 1'b1;
						st_q <= ST_POLL;
					end else begin
						st_q <= ST_IDLE;
					end
				end
				ST_POLL: if (bi.done) begin
					pend_q <= 1'b1;
					st_q <= ST_STAT;
				end
				// the device repeats its status byte while select stays low
				ST_STAT: if (bi.done) begin
					if (bi.rx[ST_READY_BIT]) begin
						cs_n_q <= 1'b1;
						poll_next_q <= 1'b0;
						st_q <= ST_GAP;
					end else begin
						pend_q <= 1'b1;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// select stays high for a minimum gap between frames
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gap_q <= 3'h0;
		end else if (st_q == ST_GAP) begin
			gap_q <= gap_q + 3'h1;
		end else begin
			gap_q <= 3'h0;
		end
	end

	// ----------------------------------------
	// captured data and flags
	// ----------------------------------------
	// device status byte: compare result and page size kept
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dstat_q <= 8'h00;
			psize_q <= 1'b0;
		end else if (st_q == ST_STAT && bi.done) begin
			dstat_q <= bi.rx;
			psize_q <= bi.rx[ST_PSIZE_BIT];
		end
	end

	// the device sram buffer is clobbered; only the host copy survives
	always_ff @(posedge CORE_CLK) begin
		if (st_q == ST_RD && bi.done) rbuf[cnt_q[6:0]] <= bi.rx;
		if (WR && ADDR == REG_WBUF) begin
			pbuf[WDATA[WBUF_IDX_LSB +: 6]] <= WDATA[7:0];
		end
	end

	// sticky flags: a set in the clear cycle wins
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_q <= 1'b0;
			refused_q <= 1'b0;
			locked_q <= 1'b0;
		end else begin
			if (finish) begin
				done_q <= 1'b1;
			end else if (WR && ADDR == REG_STAT && WDATA[STAT_DONE_BIT]) begin
				done_q <= 1'b0;
			end
			if (start_req && !go) begin
				refused_q <= 1'b1;
			end else if (WR && ADDR == REG_STAT && WDATA[STAT_REFUSED_BIT]) begin
				refused_q <= 1'b0;
			end
			if (finish && op_q == OP_SEC_PROG) locked_q <= 1'b1;
		end
	end

	// per-sector operation count; software resets it after refreshing
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wear_q <= 1'b0;
			for (int i = 0; i < 32; i++) wear_cnt[i] <= 14'h0000;
		end else begin
			if (WR && ADDR == REG_WEAR) wear_cnt[WDATA[4:0]] <= 14'h0000;
			if (go && spbc_op_e'(WDATA[2:0]) == OP_REWR) begin
				wear_cnt[sector] <= wear_cnt[sector] + 14'h0001;
			end
			if (go && spbc_op_e'(WDATA[2:0]) == OP_REWR
				&& wear_cnt[sector] >= WEAR_LIMIT - 14'h0001) begin
				wear_q <= 1'b1;
			end else if (WR && ADDR == REG_STAT && WDATA[STAT_WEAR_BIT]) begin
				wear_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	// orders are frozen while a frame runs, so the header cannot change
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			op_q <= OP_STATUS;
			buf2_q <= 1'b0;
			len_q <= 7'h00;
			page_q <= '0;
			ridx_q <= 7'h00;
			wsel_q <= 5'h00;
		end else if (WR) begin
			if (go) begin
				op_q <= spbc_op_e'(WDATA[2:0]);
				buf2_q <= WDATA[CTRL_BUF_BIT];
				len_q <= WDATA[CTRL_LEN_LSB +: 7];
			end
			if (ADDR == REG_PAGE && st_q == ST_IDLE) page_q <= WDATA[PAGE_W-1:0];
			if (ADDR == REG_RBUF) ridx_q <= WDATA[6:0];
			if (ADDR == REG_WEAR) wsel_q <= WDATA[4:0];
		end
	end

	// read data stand the cycle after the strobe only
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			if (RD) begin
				unique case (ADDR)
					REG_CTRL: rdata_q <= {17'h0, len_q, 4'h0, buf2_q, op_q};
					REG_PAGE: rdata_q <= {19'h0, page_q};
					REG_STAT: rdata_q <= {16'h0, dstat_q, 3'h0, wear_q, locked_q,
						refused_q, done_q, st_q != ST_IDLE};
					REG_RBUF: rdata_q <= {24'h0, rbuf[ridx_q]};
					REG_WEAR: rdata_q <= {18'h0, wear_cnt[wsel_q]};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign RDATA = rdata_q;
	assign CS_N = cs_n_q;
	assign SCK = bi.sck;
	assign SI = bi.si;
endmodule

// file: spbc_host_asserts.sv
`timescale 1ns/1ps
module spbc_host_asserts (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	// flash pins
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic SI,
	input wire logic SO
);
	// longest frame is the 132-byte register read, about 8.7k cycles
	localparam int FRAME_MAX = 9000;
	logic sck_q;
	logic cs_q;
	logic [15:0] rise_q;
	logic [15:0] len_q;
	// ----------------------------------------
	// frame counters
	// ----------------------------------------
	// shift edges and cycles of the open frame, cleared while deselected
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			rise_q <= 16'h0;
			len_q <= 16'h0;
		end else begin
			sck_q <= SCK;
			cs_q <= CS_N;
			rise_q <= CS_N ? 16'h0 : rise_q + 16'((SCK && !sck_q) ? 1 : 0);
			len_q <= CS_N ? 16'h0 : len_q + 16'h1;
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data not zero outside answer cycle");
	chk_sck_deselect: assert property (CS_N |-> !SCK)
		else $error("shift clock moves while deselected");
	chk_cs_gap: assert property ($rose(CS_N) |=> CS_N[*4])
		else $error("select high for under five cycles");
	chk_frame_lead: assert property ($fell(CS_N) |-> !SCK[*5])
		else $error("shift clock rose too early in frame");
	chk_sck_high: assert property ($rose(SCK) |-> SCK[*4] ##1 !SCK)
		else $error("shift clock high phase not four cycles");
	chk_sck_low: assert property ($fell(SCK) |-> !SCK[*4])
		else $error("shift clock low phase under four cycles");
	chk_si_hold: assert property (SCK && $past(SCK) |-> $stable(SI))
		else $error("serial data moved while clock high");
	chk_whole_bytes: assert property (CS_N && !cs_q |-> rise_q[2:0] == 3'h0)
		else $error("frame ended inside a byte");
	chk_frame_len: assert property (len_q < FRAME_MAX)
		else $error("frame held open too long");
endmodule
bind spbc_host spbc_host_asserts u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO));

// file: spbc_flash_model.sv
`timescale 1ns/1ps
module spbc_flash_model (
	// flash pins
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic SI,
	output logic SO,
	// behaviour knobs
	input wire logic PSIZE,
	input wire logic COMP_DIFF,
	input wire logic SLOW
);
	import spbc_pkg::*;
	// arbitrary value, seeds the factory half
	localparam logic [7:0] FACTORY_SEED = 8'ha5;
	logic [7:0] sec[128];
	logic [7:0] sbuf[64];
	logic [7:0] hdr[4];
	logic [7:0] sh;
	logic [7:0] sb;
	logic [7:0] last_op;
	logic [23:0] last_addr;
	logic ready;
	logic comp;
	logic locked;
	int nbit;
	int idx;
	// self-timed tail; only the user half is ever written
	task automatic finish_op(input logic [7:0] op);
		#(SLOW ? 20000 : 2000);
		if (op == CMD_COMP_B1 || op == CMD_COMP_B2)
			comp = COMP_DIFF;
		if (op == CMD_SEC_PROG && !locked) begin
			for (int i = 0; i < 64; i++)
				sec[i] = sbuf[i];
			locked = 1'b1;
		end
		ready = 1'b1;
	endtask
	// power-up contents
	initial begin
		SO = 1'b0;
		ready = 1'b1;
		comp = 1'b0;
		locked = 1'b0;
		nbit = 0;
		for (int i = 0; i < 128; i++)
			sec[i] = (i < 64) ? 8'hff : FACTORY_SEED ^ 8'(i);
	end
	// bits are taken on the rising shift edge
	always @(negedge CS_N) nbit = 0;
	always @(posedge SCK) begin
		if (!CS_N) begin
			sh = {sh[6:0], SI};
			nbit++;
			if (nbit % 8 == 0) begin
				idx = nbit / 8 - 1;
				if (idx < 4)
					hdr[idx] = sh;
				else if (hdr[0] == CMD_SEC_PROG && ready)
					sbuf[(idx - 4) % 64] = sh;
			end
		end
	end
	// output moves on the falling edge; undriven bits toggle so no stale value reads true
	always @(negedge SCK) begin
		sb = {ready, comp, 4'hf, 1'b0, PSIZE};
		idx = (nbit - 32) / 8;
		if (!CS_N && nbit >= 8 && hdr[0] == CMD_STATUS)
			SO = sb[7 - nbit % 8];
		else if (!CS_N && nbit >= 32 && hdr[0] == CMD_SEC_READ && idx < 128)
			SO = sec[idx][7 - nbit % 8];
		else
			SO = ~SO;
	end
	// select rising starts work; while busy everything but status and security read is ignored
	always @(posedge CS_N) begin
		SO = ~SO;
		if (ready && nbit >= 32 && hdr[0] != CMD_SEC_READ && hdr[0] != CMD_STATUS
			&& (hdr[0] != CMD_SEC_PROG || {hdr[1], hdr[2], hdr[3]} == 24'h0)) begin
			last_op = hdr[0];
			last_addr = {hdr[1], hdr[2], hdr[3]};
			ready = 1'b0;
			fork
				finish_op(hdr[0]);
			join_none
		end
	end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import spbc_pkg::*;
	logic CORE_CLK = 1'b0;
	logic RST_N, WR, RD, CS_N, SCK, SI, SO, PSIZE, COMP_DIFF, SLOW;
	logic [7:0] ADDR;
	logic [31:0] WDATA, RDATA, rv;
	int n_fail = 0;
	int check_count = 0;
	// 20 MHz core clock
	always #25 CORE_CLK = ~CORE_CLK;
	spbc_host DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO));
	spbc_flash_model FLASH (.CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO), .PSIZE(PSIZE),
		.COMP_DIFF(COMP_DIFF), .SLOW(SLOW));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	// answer stands one cycle only, so it is taken mid-cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		@(negedge CORE_CLK);
		d = RDATA;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 10000; i++) begin
			rd(REG_STAT, rv);
			if (rv[STAT_BUSY_BIT] === 1'b0)
				break;
		end
		check("stat busy", 32'h0, {31'h0, rv[STAT_BUSY_BIT]});
	endtask
	task automatic do_op(input logic [2:0] op, input logic b2, input logic [12:0] pg);
		wr(REG_PAGE, {19'h0, pg});
		wr(REG_CTRL, {28'h0, b2, op});
		wait_idle();
	endtask
	function automatic logic [7:0] exp_op(input int op, input int b);
		case (op)
			3: return b ? CMD_XFER_B2 : CMD_XFER_B1;
			4: return b ? CMD_COMP_B2 : CMD_COMP_B1;
			default: return b ? CMD_REWR_B2 : CMD_REWR_B1;
		endcase
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, well past the expected run
	initial begin
		#3000000;
		n_fail++;
		summarize();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{RST_N, WR, RD, PSIZE, COMP_DIFF, SLOW, ADDR, WDATA} = '0;
		repeat (10) @(posedge CORE_CLK);
		check("reset pins", 32'h2, {30'h0, CS_N, SCK});
		RST_N <= 1'b1;
		do_op(OP_STATUS, 1'b0, 13'h0);
		rd(REG_STAT, rv);
		check("status byte", 32'hbc, {24'h0, rv[15:8]});
		check("done flag", 32'h1, {31'h0, rv[STAT_DONE_BIT]});
		// every page opcode in both buffers, long-page layout
		for (int op = 3; op <= 5; op++) begin
			for (int b = 0; b < 2; b++) begin
				do_op(3'(op), 1'(b), 13'h1abc);
				check("opcode", {24'h0, exp_op(op, b)}, {24'h0, FLASH.last_op});
				check("address", {8'h0, 13'h1abc, 11'h0}, {8'h0, FLASH.last_addr});
			end
		end
		COMP_DIFF <= 1'b1;
		do_op(OP_COMP, 1'b1, 13'h0005);
		rd(REG_STAT, rv);
		check("compare differs", 32'h1, {31'h0, rv[14]});
		COMP_DIFF <= 1'b0;
		do_op(OP_COMP, 1'b0, 13'h0005);
		rd(REG_STAT, rv);
		check("compare equal", 32'h0, {31'h0, rv[14]});
		// binary page layout follows the status size bit
		PSIZE <= 1'b1;
		do_op(OP_STATUS, 1'b0, 13'h0);
		do_op(OP_XFER, 1'b0, 13'h1abc);
		check("binary address", {8'h0, 1'b0, 13'h1abc, 10'h0}, {8'h0, FLASH.last_addr});
		rd(REG_PAGE, rv);
		check("page readback", 32'h1abc, rv);
		PSIZE <= 1'b0;
		do_op(OP_STATUS, 1'b0, 13'h0);
		// sector count restarts on select, one rewrite counts once
		wr(REG_WEAR, 32'h1a);
		do_op(OP_REWR, 1'b1, 13'h1a00);
		rd(REG_WEAR, rv);
		check("wear count", 32'h1, {18'h0, rv[13:0]});
		// slow device; a second order while busy is refused
		SLOW <= 1'b1;
		wr(REG_STAT, 32'h16);
		wr(REG_CTRL, {29'h0, OP_XFER});
		wr(REG_CTRL, {29'h0, OP_COMP});
		wait_idle();
		rd(REG_STAT, rv);
		check("refused busy", 32'h1, {31'h0, rv[STAT_REFUSED_BIT]});
		check("busy opcode", {24'h0, CMD_XFER_B1}, {24'h0, FLASH.last_op});
		SLOW <= 1'b0;
		wr(REG_STAT, 32'h4);
		// one-time program with 66 bytes, wrapping past the user area
		for (int i = 0; i < 64; i++)
			wr(REG_WBUF, {18'h0, 6'(i), 8'(i) ^ 8'h5a});
		wr(REG_CTRL, {17'h0, 7'd66, 8'h01});
		wait_idle();
		check("program header", {CMD_SEC_PROG, 24'h0}, {FLASH.last_op, FLASH.last_addr});
		rd(REG_STAT, rv);
		check("locked", 32'h1, {31'h0, rv[STAT_LOCKED_BIT]});
		do_op(OP_SEC_READ, 1'b0, 13'h0);
		for (int i = 0; i < 128; i++) begin
			logic [7:0] eb;
			eb = (i < 64) ? 8'(i) ^ 8'h5a : FLASH.FACTORY_SEED ^ 8'(i);
			wr(REG_RBUF, 32'(i));
			rd(REG_RBUF, rv);
			check("security byte", {24'h0, eb}, rv);
		end
		// second program attempt must leave the user area alone
		wr(REG_WBUF, 32'h0);
		wr(REG_CTRL, 32'h1);
		wait_idle();
		rd(REG_STAT, rv);
		check("refused program", 32'h1, {31'h0, rv[STAT_REFUSED_BIT]});
		check("user byte kept", 32'h5a, {24'h0, FLASH.sec[0]});
		// an undefined operation code starts no frame and is flagged
		wr(REG_STAT, 32'h4);
		wr(REG_CTRL, 32'h7);
		rd(REG_STAT, rv);
		check("refused opcode", 32'h2, {30'h0, rv[STAT_REFUSED_BIT], rv[STAT_BUSY_BIT]});
		rd(8'h1c, rv);
		check("unmapped read", 32'h0, rv);
		summarize();
	end
endmodule
